// ### core/sfp_defs.vh
// Purpose: constants for the serial flash pin front end
// Assumes: included by the pin front end by bare name
// Notes: definitions only
`ifndef SFP_DEFS_VH
`define SFP_DEFS_VH
// bit positions in the read-parameter and function registers
`define SFP_RP_PAUSE_RST_BIT   7
`define SFP_FR_RST_DIS_BIT     0
// factory reset values
`define SFP_RP_RESET           8'h00
`define SFP_FR_RESET           8'h00
// serial bits in one instruction byte
`define SFP_BITS_PER_BYTE      4'h8
// lane widths
`define SFP_MODE_SINGLE        2'h0
`define SFP_MODE_DUAL          2'h1
`define SFP_MODE_QUAD          2'h2
`endif

// ### core/sfp_fifo.v
// Purpose: small first-in first-out buffer for received bytes
// Assumes: single clock, synchronous active-high reset
// Notes: storage in flip-flops, read data muxed straight from storage, not registered
`timescale 1ns/10ps
module sfp_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   // clock and reset
   input  wire             clk,
   input  wire             srst,
   // write side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // read side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wp_r;
   reg [AW-1:0]    rp_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;
   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   always @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // sfp_fifo

// ### core/sfp_pin_if.v
// Purpose: pin front end of a serial flash: select, pause, reset, serial shift
// Assumes: all pins are asynchronous to clk and pass two flip-flops first
// Notes: link clock is sampled by clk; edges are found on the synchronised copy
//
// Function
// - read-parameter bit 7 picks pause or hardware reset for the shared pin.
// - with a dedicated reset pin, shared pin acts as pause unless quad enable is set.
// - function register bit 0 set disables the dedicated reset pin.
// - select high means deselected, outputs released, standby.
// - select high ignores all serial input.
// - select low makes the device active and ready.
// - no instruction before a first falling select edge after power-up.
// - input bits sampled on rising serial clock edge.
// - output data changes on falling serial clock edge.
// - pause low while selected releases output and freezes the sequence.
// - hardware reset low holds reset with outputs released.
// - quad enable makes shared pin a data line, no pause or reset.
// - dual and quad lines are bidirectional; in on rise, out on fall.
`timescale 1ns/10ps
`include "sfp_defs.vh"
module sfp_pin_if (
   // clock and reset
   input  wire       clk,
   input  wire       srst,
   // variant strap and configuration from the register core
   input  wire       dedicated_reset_variant,
   input  wire [7:0] read_param,
   input  wire [7:0] func_reg,
   input  wire       quad_enable_bit,
   input  wire [1:0] lane_mode,
   // pins
   input  wire       sel_n_pin,
   input  wire       sck_pin,
   input  wire       rst_n_pin,
   input  wire       data_line_0_in,
   input  wire       data_line_1_in,
   input  wire       data_line_2_in,
   input  wire       data_line_3_in,
   output reg        data_line_0_out,
   output reg        data_line_0_oe,
   output reg        data_line_1_out,
   output reg        data_line_1_oe,
   output reg        data_line_2_out,
   output reg        data_line_2_oe,
   output reg        data_line_3_out,
   output reg        data_line_3_oe,
   // received bytes to the command core
   output wire       rx_valid,
   input  wire       rx_ready,
   output wire [7:0] rx_data,
   output reg        rx_overrun,
   // transmit bytes from the command core
   input  wire [7:0] tx_data,
   input  wire       tx_load,
   // status
   output reg        active,
   output reg        standby,
   output reg        in_reset,
   output reg        armed,
   output reg        byte_start
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   reg [6:0] s1_r;
   reg [6:0] s2_r;
   reg       sck_d_r;
   reg       sel_d_r;
   // sync stages run through srst, so a select held low across reset is not taken as a falling edge
   always @(posedge clk) begin
      s1_r <= {data_line_3_in, data_line_2_in, data_line_1_in, data_line_0_in, rst_n_pin, sck_pin, sel_n_pin};
      s2_r <= s1_r;
   end
   wire       sel_n   = s2_r[0];
   wire       sck     = s2_r[1];
   wire       rst_pin = s2_r[2];
   wire [3:0] din     = s2_r[6:3];
   // ****************************************
   // shared pin function
   // ****************************************
   wire pin_is_rst = !quad_enable_bit && !dedicated_reset_variant
                     && read_param[`SFP_RP_PAUSE_RST_BIT];
   wire pin_is_pause = !quad_enable_bit && !pin_is_rst;
   wire ded_rst = dedicated_reset_variant && !func_reg[`SFP_FR_RST_DIS_BIT]
                  && !rst_pin;
   wire hw_rst  = ded_rst || (pin_is_rst && !din[3]);
   wire paused  = pin_is_pause && !din[3] && !sel_n;
   wire rise    = sck && !sck_d_r;
   wire fall    = !sck && sck_d_r;
   wire sel_fall = !sel_n && sel_d_r;
   // ****************************************
   // shift engine
   // ****************************************
   reg [7:0] sh_r;
   reg [3:0] bits_r;
   reg [7:0] tx_r;
   reg       tx_dir_r;
   reg       rx_push_r;
   reg [7:0] rx_byte_r;
   reg [1:0] mode_r;
   wire      fifo_in_ready;
   wire [3:0] step = (mode_r == `SFP_MODE_QUAD) ? 4'h4 :
                     (mode_r == `SFP_MODE_DUAL) ? 4'h2 : 4'h1;
   wire      go = armed && !sel_n && !paused && !hw_rst;
   // one rising-edge step of the receive shifter; lines 3..0 carry high to low
   function [7:0] shift_in;
      input [1:0] mode;
      input [7:0] sh;
      input [3:0] d;
      begin
         case (mode)
            `SFP_MODE_QUAD: shift_in = {sh[3:0], d};
            `SFP_MODE_DUAL: shift_in = {sh[5:0], d[1:0]};
            default:        shift_in = {sh[6:0], d[0]};
         endcase
      end
   endfunction
   always @(posedge clk) begin
      if (srst) begin
         sck_d_r <= 1'b0;
         sel_d_r <= 1'b0;
         armed <= 1'b0;
         sh_r <= 8'h00;
         bits_r <= 4'h0;
         tx_r <= 8'hFF;
         tx_dir_r <= 1'b0;
         rx_push_r <= 1'b0;
         rx_byte_r <= 8'h00;
         rx_overrun <= 1'b0;
         mode_r <= `SFP_MODE_SINGLE;
         active <= 1'b0;
         standby <= 1'b1;
         in_reset <= 1'b0;
         byte_start <= 1'b0;
      end else begin
         sck_d_r <= sck;
         sel_d_r <= sel_n;
         rx_push_r <= 1'b0;
         byte_start <= 1'b0;
         // overrun is judged at the push itself, where the buffer really drops the byte
         if (rx_push_r && !fifo_in_ready) begin
            rx_overrun <= 1'b1;
         end
         // a byte may be loaded while deselected; shared lanes turn outward only after a load
         if (tx_load) begin
            tx_r <= tx_data;
            tx_dir_r <= 1'b1;
         end else if (sel_n && !sel_d_r) begin
            tx_dir_r <= 1'b0;
         end
         in_reset <= hw_rst;
         active <= !sel_n && armed && !hw_rst;
         standby <= sel_n || hw_rst;
         if (hw_rst) begin
            armed <= 1'b0;
            tx_dir_r <= 1'b0;
            mode_r <= `SFP_MODE_SINGLE;
            bits_r <= 4'h0;
         end else if (sel_n) begin
            bits_r <= 4'h0;
            mode_r <= lane_mode;
         end else begin
            if (sel_fall) begin
               armed <= 1'b1;
               byte_start <= 1'b1;
            end
            if (go && rise) begin
               sh_r <= shift_in(mode_r, sh_r, din);
               if (bits_r + step >= `SFP_BITS_PER_BYTE) begin
                  bits_r <= 4'h0;
                  rx_push_r <= 1'b1;
                  rx_byte_r <= shift_in(mode_r, sh_r, din);
               end else begin
                  bits_r <= bits_r + step;
               end
            end
            if (go && fall && !tx_load) begin
               case (mode_r)
                  `SFP_MODE_QUAD: tx_r <= {tx_r[3:0], 4'hF};
                  `SFP_MODE_DUAL: tx_r <= {tx_r[5:0], 2'h3};
                  default:        tx_r <= {tx_r[6:0], 1'b1};
               endcase
            end
         end
      end
   end
   // ****************************************
   // pin drivers, changed on falling serial clock, released at once when not driving
   // ****************************************
   wire drive = go && !sel_n;
   always @(posedge clk) begin
      if (srst) begin
         data_line_0_out <= 1'b0;
         data_line_1_out <= 1'b0;
         data_line_2_out <= 1'b0;
         data_line_3_out <= 1'b0;
         data_line_0_oe  <= 1'b0;
         data_line_1_oe  <= 1'b0;
         data_line_2_oe  <= 1'b0;
         data_line_3_oe  <= 1'b0;
      end else if (!drive) begin
         data_line_0_oe <= 1'b0;
         data_line_1_oe <= 1'b0;
         data_line_2_oe <= 1'b0;
         data_line_3_oe <= 1'b0;
      end else if (fall) begin
         // single-line output has a pin of its own; shared lanes would fight the host's write bits
         data_line_1_oe <= (mode_r == `SFP_MODE_SINGLE) || tx_dir_r;
         data_line_0_oe <= (mode_r != `SFP_MODE_SINGLE) && tx_dir_r;
         data_line_2_oe <= (mode_r == `SFP_MODE_QUAD) && tx_dir_r;
         data_line_3_oe <= (mode_r == `SFP_MODE_QUAD) && tx_dir_r;
         if (mode_r == `SFP_MODE_QUAD) begin
            {data_line_3_out, data_line_2_out, data_line_1_out, data_line_0_out} <= tx_r[7:4];
         end else if (mode_r == `SFP_MODE_DUAL) begin
            {data_line_1_out, data_line_0_out} <= tx_r[7:6];
         end else begin
            data_line_1_out <= tx_r[7];
         end
      end
   end
   // ****************************************
   // received-byte buffer
   // ****************************************
   sfp_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (rx_push_r),
      .in_ready  (fifo_in_ready),
      .in_data   (rx_byte_r),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );
endmodule // sfp_pin_if

// ### test/sfp_pin_if_sva.sv
// Purpose: assertion checker for the serial flash pin front end
// Assumes: bound to sfp_pin_if; pins pass two sync stages and one register
// Notes: windows of 5 cycles cover that latency, longer ones add slack
`timescale 1ns/10ps
module sfp_pin_if_sva (
   // clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // configuration and pins
   input wire logic       dedicated_reset_variant,
   input wire logic [7:0] read_param,
   input wire logic       quad_enable_bit,
   input wire logic       sel_n_pin,
   input wire logic       data_line_3_in,
   // observed outputs
   input wire logic       data_line_1_oe,
   input wire logic       rx_valid,
   input wire logic       active,
   input wire logic       standby,
   input wire logic       in_reset,
   input wire logic       armed,
   input wire logic       byte_start
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // shared pin is pause or reset only while the quad lines are off
   wire sh_rst = !quad_enable_bit && !dedicated_reset_variant && read_param[7] && !data_line_3_in;
   wire sh_pz  = !quad_enable_bit && !sh_rst && !data_line_3_in && !sel_n_pin;
   a_desel_float: assert property (sel_n_pin[*5] |-> !data_line_1_oe && standby)
      else $error("output driven or awake while deselected");
   a_desel_idle: assert property (sel_n_pin[*5] |-> !active)
      else $error("active while deselected");
   a_desel_quiet: assert property (sel_n_pin[*8] |-> !$rose(rx_valid))
      else $error("byte received while deselected");
   a_fall_arm: assert property ($fell(sel_n_pin) && !in_reset |-> ##[2:6] byte_start)
      else $error("select fall not seen");
   a_start_pulse: assert property (byte_start |=> !byte_start)
      else $error("start flag longer than one cycle");
   a_pause_float: assert property (sh_pz[*5] |-> !data_line_1_oe)
      else $error("output driven while paused");
   a_shared_rst: assert property (sh_rst[*5] |-> in_reset)
      else $error("shared reset not taken");
   a_rst_disarm: assert property (in_reset[*2] |-> !armed && !data_line_1_oe)
      else $error("armed or driving in reset");
   a_quad_norst: assert property ((quad_enable_bit && !dedicated_reset_variant)[*5] |-> !in_reset)
      else $error("reset taken from a quad data line");
   cover property ($rose(rx_valid));
   cover property (sh_rst[*5]);
   cover property (sh_pz[*5]);
endmodule // sfp_pin_if_sva
bind sfp_pin_if sfp_pin_if_sva i_sfp_pin_if_sva (.clk(clk), .srst(srst), .read_param(read_param),
   .dedicated_reset_variant(dedicated_reset_variant), .quad_enable_bit(quad_enable_bit), .sel_n_pin(sel_n_pin),
   .data_line_3_in(data_line_3_in), .data_line_1_oe(data_line_1_oe), .rx_valid(rx_valid), .active(active),
   .standby(standby), .in_reset(in_reset), .armed(armed), .byte_start(byte_start));

// ### test/sfp_host_model.sv
// Purpose: host controller model driving the serial flash link pins
// Assumes: mode 0, serial clock of 64 ns that stands low outside frames
// Notes: the clock waits while the shared pin holds a pause
`timescale 1ns/10ps
module sfp_host_model (
   // pins toward the device
   output logic       sel_n,
   output logic       sck,
   output logic [3:0] d,
   // shared pin level and the device's serial output
   input  wire logic  pause_n,
   input  wire logic  so,
   // serial output bits taken at each rising clock
   output logic [7:0] seen
);
   initial begin
      sel_n = 1'b0;
      sck   = 1'b0;
      d     = 4'hF;
      seen  = 8'h00;
   end
   task automatic frame(input logic [7:0] b, input int lanes, input int nbits);
      logic [7:0] s;
      s     = b;
      sel_n = 1'b0;
      #40;
      for (int i = 0; i < nbits; i += lanes) begin
         wait (pause_n);
         d = (lanes == 4) ? s[7:4] : (lanes == 2) ? {2'h3, s[7:6]} : {3'h7, s[7]};
         s = s << lanes;
         #32 sck = 1'b1;
         seen = {seen[6:0], so};
         #32 sck = 1'b0;
      end
      #40 sel_n = 1'b1;
      // released lines flip so stale bits never pass; line 3 rests on its pull-up
      #64 d = {1'b1, ~d[2:0]};
   endtask
endmodule // sfp_host_model

// ### test/tb_top.sv
// Purpose: self-checking bench for the serial flash pin front end
// Assumes: host model owns link pins, bench owns configuration and rx side
// Notes: bytes are queued when sent and compared at the rx handshake
`timescale 1ns/10ps
module tb_top;
   logic       clk, srst, ded, qe, rst_n, sh_n, stall, rx_ready, tx_load;
   logic [1:0] lane_mode;
   logic [7:0] rp, fr, tx_data;
   wire        sel_n, sck, rx_valid, rx_overrun, active, standby, in_reset, armed;
   wire  [3:0] hd, dout, oe, din;
   wire  [7:0] rx_data, seen;
   int         mismatches, compares;
   logic [7:0] exp_q[$];
   assign din[2:0] = (oe[2:0] & dout[2:0]) | (~oe[2:0] & hd[2:0]);
   assign din[3]   = oe[3] ? dout[3] : hd[3] & sh_n;
   sfp_host_model i_sfp_host_model (.sel_n(sel_n), .sck(sck), .d(hd), .pause_n(sh_n), .so(din[1]), .seen(seen));
   sfp_pin_if i_sfp_pin_if (
      .clk(clk), .srst(srst), .dedicated_reset_variant(ded), .read_param(rp), .func_reg(fr),
      .quad_enable_bit(qe), .lane_mode(lane_mode), .sel_n_pin(sel_n), .sck_pin(sck), .rst_n_pin(rst_n),
      .data_line_0_in(din[0]), .data_line_1_in(din[1]), .data_line_2_in(din[2]), .data_line_3_in(din[3]),
      .data_line_0_out(dout[0]), .data_line_0_oe(oe[0]), .data_line_1_out(dout[1]), .data_line_1_oe(oe[1]),
      .data_line_2_out(dout[2]), .data_line_2_oe(oe[2]), .data_line_3_out(dout[3]), .data_line_3_oe(oe[3]),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_overrun(rx_overrun), .tx_data(tx_data),
      .tx_load(tx_load), .active(active), .standby(standby), .in_reset(in_reset), .armed(armed), .byte_start());
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic send(input int lanes, input bit push);
      logic [7:0] b;
      b = 8'($urandom);
      if (push) exp_q.push_back(b);
      i_sfp_host_model.frame(b, lanes, 8);
   endtask
   task automatic drain();
      repeat (400) if (exp_q.size() != 0) @(posedge clk);
      cyc(1);
   endtask
   task automatic close_out();
      if (mismatches == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) #1 rx_ready = !stall && ($urandom % 4 != 0);
   always @(posedge clk) begin
      if (!srst && rx_valid === 1'b1 && rx_ready === 1'b1) begin
         check(8'(exp_q.size() != 0), 8'h01);
         if (exp_q.size() != 0) check(rx_data, exp_q.pop_front());
      end
   end
   initial begin
      #100000;
      mismatches++;
      close_out();
   end
   initial begin
      {srst, rst_n, sh_n} = 3'h7;
      {ded, qe, stall, rx_ready, tx_load, lane_mode} = 6'h00;
      {rp, fr, tx_data} = 24'h000000;
      {mismatches, compares} = 0;
      void'($urandom(81));
      cyc(12);
      srst = 1'b0;
      check(standby, 1);
      check(active, 0);
      send(1, 0);
      repeat (4) begin
         tx_data = 8'($urandom);
         tx_load = 1'b1;
         cyc(1);
         tx_load = 1'b0;
         send(1, 1);
         // the first rise comes before any fall and sees the idle line; bit 0 leaves after the last rise
         check(seen, {1'b1, tx_data[7:1]});
      end
      i_sfp_host_model.frame(8'hA5, 1, 3);
      send(1, 1);
      for (int m = 1; m < 3; m++) begin
         cyc(1);
         lane_mode = 2'(m);
         qe = (m == 2);
         send(m * 2, 1);
         send(m * 2, 1);
      end
      cyc(1);
      {lane_mode, qe} = 3'h0;
      fork
         send(1, 1);
         begin
            #200 check(active, 1);
            check(standby, 0);
            #90 sh_n = 1'b0;
            cyc(20);
            check(oe[1], 0);
            sh_n = 1'b1;
         end
      join
      cyc(1);
      rp = 8'h80;
      i_sfp_host_model.sel_n = 1'b0;
      cyc(8);
      sh_n = 1'b0;
      cyc(8);
      check(in_reset, 1);
      sh_n = 1'b1;
      cyc(8);
      check(armed, 0);
      i_sfp_host_model.sel_n = 1'b1;
      {ded, sh_n} = 2'h2;
      cyc(8);
      check(in_reset, 0);
      {sh_n, rst_n} = 2'h2;
      cyc(8);
      check(in_reset, 1);
      fr = 8'h01;
      cyc(8);
      check(in_reset, 0);
      {rst_n, ded, rp} = 10'h200;
      send(1, 1);
      drain();
      stall = 1'b1;
      for (int k = 0; k < 5; k++) send(1, k < 4);
      check(rx_overrun, 1);
      stall = 1'b0;
      drain();
      check(8'(exp_q.size()), 8'h00);
      close_out();
   end
endmodule // tb_top
